// ===== pcdr_core.sv
// Top of the PCS-to-fabric interface: byte reversal, double rate split and
// merge with word marking, and sideband transfer over fast and slow chains.
// Assumes fabric-side levels (double rate request, swap enable, sideband) arrive from outside this clock and are synchronised here.
`timescale 1ns/1ns
module pcdr_core #(
	parameter bit TX_BYTE_REV = 1'b0,
	parameter int PCS_FIFO_W = 40,
	parameter int CORE_FIFO_W = 40,
	parameter pcdr_pkg::pcdr_path_e PATH = pcdr_pkg::PCDR_PATH_STD,
	parameter int IF_W = 40
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic double_rate_req,
	output logic double_rate_active,
	input wire logic rx_byte_swap_en,
	input wire pcdr_pkg::pcdr_half_s tx_half_in,
	input wire logic tx_half_valid,
	output logic [pcdr_pkg::FULL_W-1:0] tx_pma_word,
	output logic tx_pma_valid,
	input wire logic [pcdr_pkg::FULL_W-1:0] rx_pma_word,
	input wire logic rx_pma_valid,
	output pcdr_pkg::pcdr_half_s rx_half_out,
	output logic rx_half_valid,
	input wire logic [pcdr_pkg::FAST_LEN-1:0] fast_sideband_chain_in,
	output logic [pcdr_pkg::FAST_LEN-1:0] fast_sideband_chain_out,
	input wire logic [pcdr_pkg::SLOW_LEN-1:0] slow_sideband_chain_in,
	output logic [pcdr_pkg::SLOW_LEN-1:0] slow_sideband_chain_out
);
	import pcdr_pkg::*;

	// ==========================================================
	// Helpers
	// Swap the two ten-bit bytes of each twenty-bit word; bit order inside kept.
	function automatic logic [HALF_W-1:0] byte_rev(input logic [HALF_W-1:0] d);
		logic [HALF_W-1:0] r;
		r = d;
		for (int w = 0; w < HALF_W / WORD20_W; w++) begin
			r[w*WORD20_W +: BYTE_W] = d[w*WORD20_W+BYTE_W +: BYTE_W];
			r[w*WORD20_W+BYTE_W +: BYTE_W] = d[w*WORD20_W +: BYTE_W];
		end
		return r;
	endfunction

	// Widths of ten bits or less can never run double rate.
	localparam bit DR_ALLOWED = (PCS_FIFO_W > MIN_DR_W) && (CORE_FIFO_W > MIN_DR_W);
	// Configurations whose receive marking runs upside down.
	localparam bit RX_MARK_INV = ((PATH == PCDR_PATH_ENH) && (IF_W == 32)) ||
		((PATH == PCDR_PATH_DIR) && (IF_W == 16 || IF_W == 20 || IF_W == 32));
	// Transmit reversal only in standard low latency / basic modes, all channels.
	localparam bit TX_REV_ON = TX_BYTE_REV && (PATH == PCDR_PATH_STD);
	localparam bit RX_REV_OK = (PATH == PCDR_PATH_STD);

	// ==========================================================
	// Synchronisers for asynchronous fabric-side levels
	logic [1:0] dr_sync;
	logic [1:0] swap_sync;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dr_sync <= '0;
			swap_sync <= '0;
		end else begin
			dr_sync <= {dr_sync[0], double_rate_req};
			swap_sync <= {swap_sync[0], rx_byte_swap_en};
		end
	end

	logic dr_on;
	logic swap_on;
	assign dr_on = dr_sync[1] && DR_ALLOWED;
	assign swap_on = swap_sync[1] && RX_REV_OK;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			double_rate_active <= 1'b0;
		end else begin
			double_rate_active <= dr_on;
		end
	end

	// ==========================================================
	// Transmit path: two forty-bit halves merge into one eighty-bit word.
	// The fast side is modelled by a half per valid beat, the PMA side by one
	// full word every second beat, which is the 2:1 clock ratio in enable form.
	logic [HALF_W-1:0] tx_lower;
	logic tx_have_lower;
	logic [HALF_W-1:0] tx_data_rev;
	assign tx_data_rev = TX_REV_ON ? byte_rev(tx_half_in.data) : tx_half_in.data;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_lower <= '0;
			tx_have_lower <= 1'b0;
		end else if (!dr_on) begin
			// Pairing restarts at a lower-marked half on every entry to double rate,
			// so a half left over from before the mode change never pairs.
			tx_have_lower <= 1'b0;
		end else if (tx_half_valid) begin
			// Fabric marks the lower half low, the upper half high.
			if (tx_half_in.mark == MARK_LOWER) begin
				tx_lower <= tx_data_rev;
				tx_have_lower <= 1'b1;
			end else begin
				tx_have_lower <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_pma_word <= '0;
			tx_pma_valid <= 1'b0;
		end else begin
			tx_pma_valid <= 1'b0;
			if (tx_half_valid) begin
				if (dr_on) begin
					// An upper half without a lower one is dropped rather than
					// paired with stale data.
					if (tx_half_in.mark == MARK_UPPER && tx_have_lower) begin
						tx_pma_word <= {tx_data_rev, tx_lower};
						tx_pma_valid <= 1'b1;
					end
				end else begin
					// Single rate: equal widths through, marking ignored.
					tx_pma_word <= {{(FULL_W-HALF_W){1'b0}}, tx_data_rev};
					tx_pma_valid <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Receive path: one eighty-bit word splits into two marked halves.
	logic [HALF_W-1:0] rx_upper;
	logic rx_upper_pend;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_half_out <= '0;
			rx_half_valid <= 1'b0;
			rx_upper <= '0;
			rx_upper_pend <= 1'b0;
		end else begin
			rx_half_valid <= 1'b0;
			if (rx_pma_valid) begin
				if (dr_on) begin
					// Lower half first, upper on the next cycle unless a new word arrives and replaces it.
					rx_half_out.data <= swap_on ? byte_rev(rx_pma_word[HALF_W-1:0])
						: rx_pma_word[HALF_W-1:0];
					rx_half_out.mark <= MARK_LOWER ^ RX_MARK_INV;
					rx_half_valid <= 1'b1;
					rx_upper <= rx_pma_word[FULL_W-1:HALF_W];
					rx_upper_pend <= 1'b1;
				end else begin
					rx_half_out.data <= swap_on ? byte_rev(rx_pma_word[HALF_W-1:0])
						: rx_pma_word[HALF_W-1:0];
					rx_half_out.mark <= 1'b0;
					rx_half_valid <= 1'b1;
					rx_upper_pend <= 1'b0;
				end
			end else if (rx_upper_pend) begin
				rx_half_out.data <= swap_on ? byte_rev(rx_upper) : rx_upper;
				rx_half_out.mark <= MARK_UPPER ^ RX_MARK_INV;
				rx_half_valid <= 1'b1;
				rx_upper_pend <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Sideband transfer: inbound levels are synchronised, then chained out.
	logic [FAST_LEN-1:0] fast_s1;
	logic [FAST_LEN-1:0] fast_s2;
	logic [SLOW_LEN-1:0] slow_s1;
	logic [SLOW_LEN-1:0] slow_s2;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fast_s1 <= '0;
			fast_s2 <= '0;
			slow_s1 <= '0;
			slow_s2 <= '0;
		end else begin
			fast_s1 <= fast_sideband_chain_in;
			fast_s2 <= fast_s1;
			slow_s1 <= slow_sideband_chain_in;
			slow_s2 <= slow_s1;
		end
	end

	// Short chain for timing-critical signals, long one for the rest.
	pcdr_sideband_chain #(
		.LEN(FAST_LEN),
		.DIV(FAST_DIV)
	) u_fast (
		.clock(clock),
		.rst(rst),
		.sb_in(fast_s2),
		.sb_out(fast_sideband_chain_out),
		.update_done()
	);

	pcdr_sideband_chain #(
		.LEN(SLOW_LEN),
		.DIV(SLOW_DIV)
	) u_slow (
		.clock(clock),
		.rst(rst),
		.sb_in(slow_s2),
		.sb_out(slow_sideband_chain_out),
		.update_done()
	);
endmodule

// ===== pcdr_core_monitor.sv
// Concurrent checks on the ports of the double rate and sideband top.
// Assumes default widths, standard path and fabric holding sideband inputs.
`timescale 1ns/1ns
module pcdr_core_monitor
	import pcdr_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic double_rate_req,
	input wire logic double_rate_active,
	input wire pcdr_pkg::pcdr_half_s tx_half_in,
	input wire logic tx_half_valid,
	input wire logic [pcdr_pkg::FULL_W-1:0] tx_pma_word,
	input wire logic tx_pma_valid,
	input wire logic rx_pma_valid,
	input wire pcdr_pkg::pcdr_half_s rx_half_out,
	input wire logic rx_half_valid,
	input wire logic [pcdr_pkg::FAST_LEN-1:0] fast_sideband_chain_in,
	input wire logic [pcdr_pkg::FAST_LEN-1:0] fast_sideband_chain_out,
	input wire logic [pcdr_pkg::SLOW_LEN-1:0] slow_sideband_chain_in,
	input wire logic [pcdr_pkg::SLOW_LEN-1:0] slow_sideband_chain_out
);
	// ========================================
	// Input age counters
	// Ages restart on any input change, so output checks only fire on held inputs.
	logic [7:0] fast_age;
	logic [7:0] slow_age;
	logic [FAST_LEN-1:0] fast_q;
	logic [SLOW_LEN-1:0] slow_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fast_q <= '0;
			fast_age <= 8'h00;
		end else begin
			fast_q <= fast_sideband_chain_in;
			if (fast_q != fast_sideband_chain_in) fast_age <= 8'h00;
			else if (fast_age != 8'hFF) fast_age <= fast_age + 8'h01;
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			slow_q <= '0;
			slow_age <= 8'h00;
		end else begin
			slow_q <= slow_sideband_chain_in;
			if (slow_q != slow_sideband_chain_in) slow_age <= 8'h00;
			else if (slow_age != 8'hFF) slow_age <= slow_age + 8'h01;
		end
	end
	// ========================================
	// Properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_tx_pair;
		double_rate_active && tx_half_valid && tx_half_in.mark == MARK_LOWER ##1
		double_rate_active && tx_half_valid && tx_half_in.mark == MARK_UPPER |=>
		tx_pma_valid && tx_pma_word == {$past(tx_half_in.data), $past(tx_half_in.data, 2)};
	endproperty
	a_tx_pair: assert property (p_tx_pair) else $error("tx pair not merged");
	property p_tx_single;
		!double_rate_active && tx_half_valid |=>
		tx_pma_valid && tx_pma_word == {40'h0, $past(tx_half_in.data)};
	endproperty
	a_tx_single: assert property (p_tx_single) else $error("single rate tx word wrong");
	property p_rx_marks;
		rx_pma_valid && double_rate_active ##1 !rx_pma_valid && double_rate_active |->
		rx_half_valid && rx_half_out.mark == MARK_LOWER ##1
		rx_half_valid && rx_half_out.mark == MARK_UPPER;
	endproperty
	a_rx_marks: assert property (p_rx_marks) else $error("rx marks wrong");
	property p_dr_on;
		double_rate_req [*5] |-> double_rate_active;
	endproperty
	a_dr_on: assert property (p_dr_on) else $error("double rate not entered");
	property p_dr_off;
		!double_rate_req [*5] |-> !double_rate_active;
	endproperty
	a_dr_off: assert property (p_dr_off) else $error("double rate not left");
	property p_fast;
		fast_age == 8'h28 |-> fast_sideband_chain_out == fast_sideband_chain_in;
	endproperty
	a_fast: assert property (p_fast) else $error("fast chain out stale");
	property p_slow;
		slow_age == 8'h64 |-> slow_sideband_chain_out == slow_sideband_chain_in;
	endproperty
	a_slow: assert property (p_slow) else $error("slow chain out stale");
	property p_fast_late;
		$changed(fast_sideband_chain_out) |-> fast_age >= 8'h07;
	endproperty
	a_fast_late: assert property (p_fast_late) else $error("fast out changed early");
endmodule

bind pcdr_core pcdr_core_monitor pcdr_core_monitor_i (.*);

// ===== pcdr_fabric_model.sv
// Fabric user logic model: sends words as marked halves, realigns received halves.
// Assumes the core's clock; send is a one-cycle pulse spaced at least 3 cycles.
`timescale 1ns/1ns
module pcdr_fabric_model
	import pcdr_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic send,
	input wire logic [pcdr_pkg::FULL_W-1:0] send_word,
	output pcdr_pkg::pcdr_half_s tx_half_in,
	output logic tx_half_valid,
	input wire pcdr_pkg::pcdr_half_s rx_half_out,
	input wire logic rx_half_valid,
	output logic [pcdr_pkg::FULL_W-1:0] rx_word,
	output logic rx_word_valid
);
	// ========================================
	// Transmit halves
	logic pend;
	logic have_lo;
	logic have_hi;
	logic [HALF_W-1:0] up;
	logic [HALF_W-1:0] lo;
	logic [HALF_W-1:0] hi;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_half_valid <= 1'b0;
			tx_half_in <= '0;
			pend <= 1'b0;
		end else if (send) begin
			tx_half_in <= '{mark: MARK_LOWER, data: send_word[HALF_W-1:0]};
			tx_half_valid <= 1'b1;
			up <= send_word[FULL_W-1:HALF_W];
			pend <= 1'b1;
		end else if (pend) begin
			tx_half_in <= '{mark: MARK_UPPER, data: up};
			pend <= 1'b0;
		end else begin
			// Idle data toggles so a core that latches stale halves is caught.
			tx_half_valid <= 1'b0;
			tx_half_in.data <= ~tx_half_in.data;
		end
	end
	// ========================================
	// Receive realignment
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			have_lo <= 1'b0;
			have_hi <= 1'b0;
			rx_word_valid <= 1'b0;
		end else begin
			rx_word_valid <= 1'b0;
			if (rx_half_valid && rx_half_out.mark == MARK_UPPER) begin
				if (have_lo) begin
					rx_word <= {rx_half_out.data, lo};
					rx_word_valid <= 1'b1;
					have_lo <= 1'b0;
				end else begin
					hi <= rx_half_out.data;
					have_hi <= 1'b1;
				end
			end else if (rx_half_valid) begin
				if (have_hi) begin
					rx_word <= {hi, rx_half_out.data};
					rx_word_valid <= 1'b1;
					have_hi <= 1'b0;
				end else begin
					lo <= rx_half_out.data;
					have_lo <= 1'b1;
				end
			end
		end
	end
endmodule

// ===== pcdr_pkg.sv
// Package for the PCS-to-fabric double rate and sideband block.
// Assumes a single 125 MHz clock domain; slower rates come from enable pulses.
package pcdr_pkg;
	localparam int HALF_W = 40;
	localparam int FULL_W = 80;
	localparam int BYTE_W = 10;
	localparam int WORD20_W = 20;
	localparam int MIN_DR_W = 10;
	localparam int FAST_LEN = 8;
	localparam int SLOW_LEN = 32;
	localparam int FAST_HOLD_CYC = 10;
	localparam int SLOW_HOLD_CYC = 120;
	localparam int CLK_MHZ = 125;
	localparam int FAST_HOLD_NS = 17;
	localparam int SLOW_HOLD_NS = 201;
	// Chain shift rate: one enable per clock; figures above are oscillator cycles.
	localparam int FAST_DIV = 1;
	localparam int SLOW_DIV = (SLOW_HOLD_NS * CLK_MHZ + 999) / 1000 / SLOW_HOLD_CYC + 1;
	localparam int CNT_W = 8;
	localparam logic MARK_LOWER = 1'b0;
	localparam logic MARK_UPPER = 1'b1;

	typedef enum logic [2:0] {
		PCDR_PATH_STD = 3'h1,
		PCDR_PATH_ENH = 3'h2,
		PCDR_PATH_DIR = 3'h4
	} pcdr_path_e;

	typedef struct packed {
		logic mark;
		logic [HALF_W-1:0] data;
	} pcdr_half_s;

	typedef enum logic [2:0] {
		PCDR_CH_LOAD = 3'h1,
		PCDR_CH_SHIFT = 3'h2,
		PCDR_CH_UPDATE = 3'h4
	} pcdr_chain_e;
endpackage

// ===== pcdr_sideband_chain.sv
// One sideband shift chain: capture, serial shift, then update of outputs.
// Assumes inputs are already synchronised and held long enough by the fabric.
`timescale 1ns/1ns
module pcdr_sideband_chain #(
	parameter int LEN = 8,
	parameter int DIV = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [LEN-1:0] sb_in,
	output logic [LEN-1:0] sb_out,
	output logic update_done
);
	import pcdr_pkg::*;

	pcdr_chain_e state;
	logic [LEN-1:0] shreg;
	logic [CNT_W-1:0] bit_cnt;
	logic [CNT_W-1:0] div_cnt;
	logic tick;

	// ==========================================================
	// Shift rate divider
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_cnt <= '0;
		end else if (div_cnt == CNT_W'(DIV - 1)) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end
	assign tick = (div_cnt == CNT_W'(DIV - 1));

	// ==========================================================
	// Capture, shift and update sequence
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= PCDR_CH_LOAD;
			shreg <= '0;
			bit_cnt <= '0;
		end else if (tick) begin
			case (state)
				PCDR_CH_LOAD: begin
					shreg <= sb_in;
					bit_cnt <= '0;
					state <= PCDR_CH_SHIFT;
				end
				PCDR_CH_SHIFT: begin
					// Rotation brings the word back to its place after LEN shifts.
					shreg <= {shreg[0], shreg[LEN-1:1]};
					bit_cnt <= bit_cnt + 1'b1;
					if (bit_cnt == CNT_W'(LEN - 1)) begin
						state <= PCDR_CH_UPDATE;
					end
				end
				PCDR_CH_UPDATE: begin
					state <= PCDR_CH_LOAD;
				end
				default: begin
					state <= PCDR_CH_LOAD;
				end
			endcase
		end
	end

	// Outputs move only once a full pass has finished, never mid-shift.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sb_out <= '0;
			update_done <= 1'b0;
		end else begin
			update_done <= tick && (state == PCDR_CH_UPDATE);
			if (tick && state == PCDR_CH_UPDATE) begin
				sb_out <= shreg;
			end
		end
	end

endmodule

// ===== test_pcdr_core.sv
// Self-checking bench for the double rate and sideband top with a fabric model.
// Assumes default parameters: 40-bit FIFOs, standard path, no tx byte reversal.
`timescale 1ns/1ns
module test_pcdr_core;
	import pcdr_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic double_rate_req = 1'b0;
	logic rx_byte_swap_en = 1'b0;
	logic rx_pma_valid = 1'b0;
	logic send = 1'b0;
	logic [FULL_W-1:0] rx_pma_word = '0;
	logic [FULL_W-1:0] send_word = '0;
	logic [FAST_LEN-1:0] fast_sideband_chain_in = '0;
	logic [SLOW_LEN-1:0] slow_sideband_chain_in = '0;
	logic [FAST_LEN-1:0] fast_sideband_chain_out;
	logic [SLOW_LEN-1:0] slow_sideband_chain_out;
	logic [FULL_W-1:0] tx_pma_word;
	logic [FULL_W-1:0] rx_word;
	logic double_rate_active, tx_half_valid, tx_pma_valid, rx_half_valid, rx_word_valid;
	pcdr_half_s tx_half_in;
	pcdr_half_s rx_half_out;
	logic [95:0] r;
	int bad_count = 0;
	int compares = 0;
	initial forever #4 clock = ~clock;
	pcdr_core pcdr_core_i (.*);
	pcdr_fabric_model pcdr_fabric_model_i (.*);
	// ========================================
	// Helpers
	task automatic check(input string what, input logic [FULL_W-1:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	function automatic logic [FULL_W-1:0] swap_bytes(input logic [FULL_W-1:0] w);
		logic [FULL_W-1:0] s;
		for (int i = 0; i < 4; i++) begin
			s[i*20 +: 10] = w[i*20+10 +: 10];
			s[i*20+10 +: 10] = w[i*20 +: 10];
		end
		return s;
	endfunction
	// Launches one word on both paths; rx spacing stays above two cycles.
	task automatic launch(input logic [FULL_W-1:0] w);
		@(posedge clock);
		send <= 1'b1;
		send_word <= w;
		rx_pma_word <= w;
		rx_pma_valid <= 1'b1;
		@(posedge clock);
		send <= 1'b0;
		rx_pma_valid <= 1'b0;
		rx_pma_word <= ~w;
	endtask
	task automatic pair(input logic [FULL_W-1:0] w, input logic swp);
		logic gt;
		logic gr;
		gt = 1'b0;
		gr = 1'b0;
		launch(w);
		for (int n = 0; n < 20 && !(gt && gr); n++) begin
			@(posedge clock);
			#1;
			if (tx_pma_valid === 1'b1) begin
				gt = 1'b1;
				check("tx word", tx_pma_word, w);
			end
			if (rx_word_valid === 1'b1) begin
				gr = 1'b1;
				check("rx word", rx_word, swp ? swap_bytes(w) : w);
			end
		end
		if (!(gt && gr)) begin
			bad_count++;
			report_and_stop();
		end
	endtask
	task automatic single(input logic [FULL_W-1:0] w);
		int n;
		launch(w);
		#1;
		check("rx single", {38'h0, rx_half_valid, rx_half_out}, {38'h0, 1'b1, MARK_LOWER, w[39:0]});
		for (n = 0; n < 10 && tx_pma_valid !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		if (n == 10) begin
			bad_count++;
			report_and_stop();
		end
		check("tx single lo", tx_pma_word, {40'h0, w[39:0]});
		@(posedge clock);
		#1;
		check("tx single hi", {tx_pma_valid, tx_pma_word[78:0]}, {1'b1, 39'h0, w[79:40]});
	endtask
	// ========================================
	// Main sequence
	initial begin
		void'($urandom(32'h5438950e));
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		double_rate_req <= 1'b1;
		repeat (8) @(posedge clock);
		pair('0, 1'b0);
		pair('1, 1'b0);
		repeat (12) begin
			r = {$urandom, $urandom, $urandom};
			pair(r[79:0], 1'b0);
		end
		rx_byte_swap_en <= 1'b1;
		repeat (4) @(posedge clock);
		repeat (6) begin
			r = {$urandom, $urandom, $urandom};
			pair(r[79:0], 1'b1);
		end
		rx_byte_swap_en <= 1'b0;
		repeat (4) begin
			r = {$urandom, $urandom, $urandom};
			@(posedge clock);
			fast_sideband_chain_in <= r[7:0];
			slow_sideband_chain_in <= r[95:64];
			repeat (120) @(posedge clock);
			#1;
			check("fast sideband", {72'h0, fast_sideband_chain_out}, {72'h0, r[7:0]});
			check("slow sideband", {48'h0, slow_sideband_chain_out}, {48'h0, r[95:64]});
		end
		double_rate_req <= 1'b0;
		repeat (8) @(posedge clock);
		repeat (4) begin
			r = {$urandom, $urandom, $urandom};
			single(r[79:0]);
		end
		report_and_stop();
	end
endmodule
